// ===== verilog/rsq_pkg.sv
/*
 * rsq_pkg: constants and types for the reset sequencer.
 * assumes a single 200 MHz clock; all times except T_FUNC_LONG_MAX_US are converted to cycles here.
 */
package rsq_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;

    // sequence durations as printed, in their own units
    localparam int unsigned T_DEST_BIST_MIN_MS = 25;
    localparam int unsigned T_DEST_NOBIST_MAX_US = 90;
    localparam int unsigned T_FUNC_LONG_MIN_US = 50;
    localparam int unsigned T_FUNC_LONG_MAX_US = 90;
    localparam int unsigned T_FUNC_SHORT_MIN_US = 2;
    localparam int unsigned T_FUNC_SHORT_MAX_US = 7;

    // cycle counts; each sequence aims at its least time, rounded up; destructive without self-test uses the functional long least time
    localparam longint unsigned CYC_DEST_BIST =
        (longint'(T_DEST_BIST_MIN_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned CYC_FUNC_LONG =
        (longint'(T_FUNC_LONG_MIN_US) * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned CYC_DEST_NOBIST = CYC_FUNC_LONG;
    localparam longint unsigned CYC_FUNC_SHORT =
        (longint'(T_FUNC_SHORT_MIN_US) * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned CYC_DEST_NOBIST_MAX =
        longint'(T_DEST_NOBIST_MAX_US) * 1000000 / CLK_PERIOD_PS;
    localparam longint unsigned CYC_FUNC_SHORT_MAX =
        longint'(T_FUNC_SHORT_MAX_US) * 1000000 / CLK_PERIOD_PS;

    localparam int unsigned CNT_W = 24;
    localparam int unsigned SYNC_STAGES = 2;

    // the five sequence kinds
    typedef enum logic [2:0] {
        RSQ_DEST_BIST,
        RSQ_DEST_NOBIST,
        RSQ_EXT_LONG,
        RSQ_FUNC_LONG,
        RSQ_FUNC_SHORT
    } rsq_kind_t;

    // a functional reset request with its pin drive enable
    typedef struct packed {
        logic req_long;
        logic req_short;
        logic functional_reset_pin_drive_enable;
    } rsq_func_req_t;

    // status seen by the rest of the device
    typedef struct packed {
        logic      in_reset;
        logic      done;
        rsq_kind_t kind;
    } rsq_status_t;

endpackage : rsq_pkg

// ===== verilog/rsq_sync.sv
/*
 * rsq_sync: two-flop level synchroniser with constant reset value.
 * assumes the input is an asynchronous level; only the last stage is used.
 */
`timescale 1ns/100ps
module rsq_sync
    import rsq_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic [SYNC_STAGES-1:0] stage_ff;
    logic [SYNC_STAGES-1:0] nxt_stage;

    // shift in the raw level
    always_comb begin
        nxt_stage = {stage_ff[SYNC_STAGES-2:0], i_async};
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stage_ff <= {SYNC_STAGES{RST_VAL}};
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    assign o_sync = stage_ff[SYNC_STAGES-1];
endmodule // rsq_sync

// ===== verilog/rsq_sequencer.sv
/*
 * rsq_sequencer: device reset sequencer and shared reset pin control.
 * assumes power_on_reset_in_n and the reset pin come from outside and are
 * synchronised here; functional requests and the self-test select are
 * synchronous inputs from the device's reset generation logic.
 */
// What this block does
// RQ1 - start sequence when power-on reset releases
// RQ2 - host holds power-on reset until supplies stable
// RQ3 - reset pin only pulled low, never high
// RQ4 - release pin at end of sequence
// RQ5 - hold reset while pin held low externally
// RQ6 - functional sequences drive pin only if enabled
// RQ7 - five sequence kinds supported
// RQ8 - destructive with self-test lasts at least 25ms
// RQ9 - destructive without self-test within 90us
// RQ10 - functional long lasts 50 to 90us
// RQ11 - functional short lasts 2 to 7us
// RQ12 - synchronise inputs, phase lengths as counts
`timescale 1ns/100ps
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int unsigned P_CYC_DEST_BIST   = 32'(CYC_DEST_BIST),
    parameter int unsigned P_CYC_DEST_NOBIST = 32'(CYC_DEST_NOBIST),
    parameter int unsigned P_CYC_FUNC_LONG   = 32'(CYC_FUNC_LONG),
    parameter int unsigned P_CYC_FUNC_SHORT  = 32'(CYC_FUNC_SHORT)
) (
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    input  wire logic    i_power_on_reset_in_n,
    input  wire logic    i_reset_pin_in_n,
    input  wire logic    i_self_test_en,
    input  wire rsq_func_req_t i_func_req,
    output logic         o_reset_pin_out,
    output logic         o_reset_pin_oe_n,
    output rsq_status_t  o_status
);
    typedef enum logic [2:0] {
        ST_POR,
        ST_RUN,
        ST_THIRD_PHASE,
        ST_DONE
    } rsq_state_t;

    rsq_state_t  state_ff,  nxt_state;
    rsq_kind_t   kind_ff,   nxt_kind;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic        drive_ff,  nxt_drive;
    logic        done_ff,   nxt_done;
    logic        por_n_s;
    logic        pin_n_s;
    logic        oe_n_ff,     nxt_oe_n;
    logic        in_reset_ff, nxt_in_reset;

    // length of each sequence in cycles
    function automatic logic [CNT_W-1:0] seq_len(input rsq_kind_t k);
        case (k)
            RSQ_DEST_BIST:   seq_len = CNT_W'(P_CYC_DEST_BIST);   // RQ8
            RSQ_DEST_NOBIST: seq_len = CNT_W'(P_CYC_DEST_NOBIST); // RQ9
            RSQ_EXT_LONG:    seq_len = CNT_W'(P_CYC_DEST_BIST);
            RSQ_FUNC_LONG:   seq_len = CNT_W'(P_CYC_FUNC_LONG);   // RQ10
            RSQ_FUNC_SHORT:  seq_len = CNT_W'(P_CYC_FUNC_SHORT);  // RQ11
            default:         seq_len = CNT_W'(P_CYC_DEST_NOBIST);
        endcase
    endfunction

    // input synchronisers
    rsq_sync #(.RST_VAL(1'b0)) u_sync_por ( // RQ12
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_power_on_reset_in_n),
        .o_sync  (por_n_s)
    );
    rsq_sync #(.RST_VAL(1'b0)) u_sync_pin ( // RQ12
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_reset_pin_in_n),
        .o_sync  (pin_n_s)
    );

    // sequence state machine
    always_comb begin
        nxt_state    = state_ff;
        nxt_kind     = kind_ff;
        nxt_cnt      = cnt_ff;
        nxt_drive    = drive_ff;
        nxt_done     = done_ff;
        case (state_ff)
            ST_POR: begin
                nxt_drive = 1'b1;
                nxt_done  = 1'b0;
                if (por_n_s) begin // RQ1
                    // self-test choice picks the destructive flavour
                    nxt_kind  = i_self_test_en ? RSQ_DEST_BIST : RSQ_DEST_NOBIST; // RQ7
                    nxt_cnt   = seq_len(i_self_test_en ? RSQ_DEST_BIST : RSQ_DEST_NOBIST);
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cnt_ff > CNT_W'(1)) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end else begin
                    nxt_cnt   = '0;
                    nxt_state = ST_THIRD_PHASE;
                end
            end
            ST_THIRD_PHASE: begin
                // release our pull, then wait for the wire to rise
                nxt_drive = 1'b0; // RQ4
                if (pin_n_s && !drive_ff) begin // RQ5
                    nxt_state = ST_DONE;
                    nxt_done  = 1'b1;
                end
            end
            ST_DONE: begin
                if (!pin_n_s) begin
                    // external reset: long sequence with self-test
                    nxt_kind  = RSQ_EXT_LONG; // RQ7
                    nxt_cnt   = seq_len(RSQ_EXT_LONG);
                    nxt_drive = 1'b1;
                    nxt_done  = 1'b0;
                    nxt_state = ST_RUN;
                end else if (i_func_req.req_long || i_func_req.req_short) begin
                    nxt_kind  = i_func_req.req_long ? RSQ_FUNC_LONG : RSQ_FUNC_SHORT;
                    nxt_cnt   = seq_len(i_func_req.req_long ? RSQ_FUNC_LONG : RSQ_FUNC_SHORT);
                    nxt_drive = i_func_req.functional_reset_pin_drive_enable; // RQ6
                    nxt_done  = 1'b0;
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_POR;
            end
        endcase
        // a power-on reset assertion returns to ST_POR, pulls the pin and clears done
        if (!por_n_s) begin
            nxt_state = ST_POR;
            nxt_drive = 1'b1;
            nxt_done  = 1'b0;
        end
        // pin enable and status kept as their own flops
        nxt_oe_n     = ~nxt_drive; // RQ3
        nxt_in_reset = ~nxt_done;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff    <= ST_POR;
            kind_ff     <= RSQ_DEST_NOBIST;
            cnt_ff      <= '0;
            drive_ff    <= 1'b1;
            done_ff     <= 1'b0;
            oe_n_ff     <= 1'b0;
            in_reset_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            kind_ff     <= nxt_kind;
            cnt_ff      <= nxt_cnt;
            drive_ff    <= nxt_drive;
            done_ff     <= nxt_done;
            oe_n_ff     <= nxt_oe_n;
            in_reset_ff <= nxt_in_reset;
        end
    end

    // open-drain pin: data always low, enable low while pulling
    assign o_reset_pin_out  = 1'b0;       // RQ3
    assign o_reset_pin_oe_n = oe_n_ff;    // RQ3
    assign o_status.in_reset = in_reset_ff;
    assign o_status.done     = done_ff;
    assign o_status.kind     = kind_ff;

    // pin data never high
    a_pin_never_high: assert property ( // RQ3
        @(posedge i_clock) disable iff (i_rst) o_reset_pin_out == 1'b0
    ) else $error("reset pin driven high");

    // sequence starts the edge after synchronised power-on release
    a_por_start: assert property ( // RQ1
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_POR && por_n_s) |=> (state_ff == ST_RUN)
    ) else $error("sequence did not start on power-on release");

    // pull released once third phase reached
    a_pin_release: assert property ( // RQ4
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_THIRD_PHASE && por_n_s) |=> !drive_ff
    ) else $error("pin still pulled after sequence end");

    // done held off while pin low externally
    a_ext_hold: assert property ( // RQ5
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_THIRD_PHASE && !pin_n_s) |=> !done_ff
    ) else $error("reset ended while pin held low");

    // short functional sequence pull follows the enable
    a_func_drive: assert property ( // RQ6
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_DONE && pin_n_s && por_n_s && i_func_req.req_short
         && !i_func_req.req_long)
        |=> (drive_ff == $past(i_func_req.functional_reset_pin_drive_enable))
    ) else $error("functional pull does not follow enable");

    // short functional count stays within its 7us bound
    a_short_len: assert property ( // RQ11
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_RUN && kind_ff == RSQ_FUNC_SHORT)
        |-> (cnt_ff <= CNT_W'(CYC_FUNC_SHORT_MAX))
    ) else $error("short functional count too long");

    // destructive without self-test within bound
    a_nobist_len: assert property ( // RQ9
        @(posedge i_clock) disable iff (i_rst)
        (state_ff == ST_RUN && kind_ff == RSQ_DEST_NOBIST)
        |-> (cnt_ff <= CNT_W'(CYC_DEST_NOBIST_MAX))
    ) else $error("destructive count too long");

    // run loads its full count on entry
    a_run_load: assert property ( // RQ12
        @(posedge i_clock) disable iff (i_rst)
        (state_ff != ST_RUN ##1 state_ff == ST_RUN) |-> (cnt_ff == seq_len(kind_ff))
    ) else $error("run count not loaded");

endmodule // rsq_sequencer

// ===== verification/rsq_rst_gen.sv
/*
 * rsq_rst_gen: external reset generator beside the shared reset pin.
 * assumes commands from the bench shortly after the rising edge.
 */
`timescale 1ns/100ps
module rsq_rst_gen (
    input  wire logic i_clock,
    input  wire logic i_por_req,
    input  wire logic i_hold,
    input  wire logic i_oe_n,
    input  wire logic i_pin_out,
    output logic      o_por_n,
    output logic      o_pin_n
);
    int stable_cnt = 0;
    // supplies settle before power-on is let go
    always @(posedge i_clock) begin
        stable_cnt <= i_por_req ? stable_cnt + 1 : 0;
    end
    assign o_por_n = i_por_req && (stable_cnt >= 3);
    // wired pin: pull-up, each side may only pull low
    assign o_pin_n = (i_oe_n ? 1'b1 : i_pin_out) & ~i_hold;
endmodule // rsq_rst_gen

// ===== verification/test_reset_sequence_pin_control.sv
/*
 * test_reset_sequence_pin_control: self-checking bench for rsq_sequencer.
 * assumes small phase counts; rsq_rst_gen stands on the pin side.
 */
`timescale 1ns/100ps
module test_reset_sequence_pin_control;
    import rsq_pkg::*;
    localparam int L_DB = 20, L_DN = 10, L_FL = 10, L_FS = 4;
    logic          i_clock = 0, i_rst = 1, por_req = 0, hold = 0, self_test = 1;
    logic          por_n, pin_n, pin_out, oe_n;
    rsq_func_req_t func_req = '0;
    rsq_status_t   status;
    int            bad_count = 0, cmp_count = 0, cyc = 0;
    logic [31:0]   seed = 32'h84DF;
    bit            en;

    rsq_sequencer #(.P_CYC_DEST_BIST(L_DB), .P_CYC_DEST_NOBIST(L_DN),
        .P_CYC_FUNC_LONG(L_FL), .P_CYC_FUNC_SHORT(L_FS)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_power_on_reset_in_n(por_n),
        .i_reset_pin_in_n(pin_n), .i_self_test_en(self_test),
        .i_func_req(func_req), .o_reset_pin_out(pin_out),
        .o_reset_pin_oe_n(oe_n), .o_status(status));
    rsq_rst_gen gen (.i_clock(i_clock), .i_por_req(por_req), .i_hold(hold),
        .i_oe_n(oe_n), .i_pin_out(pin_out), .o_por_n(por_n), .o_pin_n(pin_n));

    // clock and hang guard
    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            close_out();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // model: nominal length of each sequence kind
    function automatic int exp_len(rsq_kind_t k);
        case (k)
            RSQ_DEST_BIST, RSQ_EXT_LONG: return L_DB;
            RSQ_DEST_NOBIST: return L_DN;
            RSQ_FUNC_LONG: return L_FL;
            default: return L_FS;
        endcase
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // follow one sequence from its trigger to done
    task automatic run_seq(rsq_kind_t k, bit drive, int hold_n);
        int n;
        bit started, pulled;
        n = 0;
        started = 0;
        pulled = 0;
        while (!(started && status.done === 1'b1) && n < 400) begin
            if (status.in_reset === 1'b1) started = 1;
            if (started) func_req = '0;
            if (oe_n === 1'b0) pulled = 1;
            if (n == hold_n) hold = 0;
            check("pin_out", pin_out, 0);
            @(posedge i_clock);
            #1;
            n++;
        end
        check("kind", status.kind, k);
        check("drive", pulled, drive);
        check("oe_n_end", oe_n, 1);
        check("min_len", n >= exp_len(k), 1);
        check("max_len", n <= exp_len(k) + hold_n + 16, 1);
        check("held", n > hold_n, 1);
    endtask

    initial begin
        repeat (5) @(posedge i_clock);
        #1 i_rst = 0;
        // power-on starts: with self-test, then without and pin held
        for (int i = 0; i < 2; i++) begin
            por_req = 0;
            repeat (4) @(posedge i_clock);
            #1 self_test = (i == 0);
            hold = (i == 1);
            por_req = 1;
            run_seq(i ? RSQ_DEST_NOBIST : RSQ_DEST_BIST, 1,
                i ? 30 + int'(rnd() % 32) : 0);
        end
        // external pulse on the pin while idle
        hold = 1;
        run_seq(RSQ_EXT_LONG, 1, 3);
        // functional long, short, and both at once
        for (int i = 0; i < 3; i++) begin
            en = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'(rnd() & 32'h1);
            func_req = '{i != 1, i != 0, en};
            run_seq(i == 1 ? RSQ_FUNC_SHORT : RSQ_FUNC_LONG, en, 0);
        end
        // power-on asserted mid-sequence aborts it
        func_req = '{1'b1, 1'b0, 1'b1};
        repeat (5) @(posedge i_clock);
        #1 por_req = 0;
        func_req = '0;
        // wait past the point where an unaborted run would have ended
        repeat (20) @(posedge i_clock);
        #1;
        check("abort_rst", status.in_reset, 1);
        check("abort_done", status.done, 0);
        check("abort_oe", oe_n, 0);
        self_test = 0;
        por_req = 1;
        run_seq(RSQ_DEST_NOBIST, 1, 0);
        close_out();
    end
endmodule // test_reset_sequence_pin_control
